/* common/amtc_pkg.sv */
// Package for the asynchronous memory timing and configuration block.
// Assumes a 32-bit APB register bus and four chip-select spaces.
package amtc_pkg;

    // Register byte offsets
    localparam logic [7:0] AMTC_OFF_WAIT_CFG   = 8'h04;
    localparam logic [7:0] AMTC_OFF_SPACE_BASE = 8'h10;  // Space n at base + 4n
    localparam logic [7:0] AMTC_OFF_INT_STATUS = 8'h40;
    localparam logic [7:0] AMTC_OFF_INT_MASK   = 8'h44;
    localparam logic [7:0] AMTC_OFF_ACC_STATUS = 8'h48;

    // Reset values
    localparam logic [31:0] AMTC_RST_WAIT_CFG  = 32'hF0E4_0080;
    localparam logic [31:0] AMTC_RST_SPACE_CFG = 32'h3FFF_FFFC;
    localparam logic [31:0] AMTC_RST_INT       = 32'h0000_0000;

    // Writable bits; reserved bits read back as zero
    localparam logic [31:0] AMTC_WAIT_CFG_WMASK = 32'hF0FF_00FF;
    localparam logic [31:0] AMTC_INT_BITS       = 32'h0000_003D;

    // Interrupt field positions
    localparam int AMTC_INT_TIMEOUT_BIT = 0;
    localparam int AMTC_INT_RISE_LSB    = 2;

    // Extension granularity in controller clock cycles
    localparam int AMTC_EXT_WAIT_UNIT = 16;

    // Data bus width codes
    localparam logic [1:0] AMTC_WIDTH_8  = 2'h0;
    localparam logic [1:0] AMTC_WIDTH_16 = 2'h1;

    typedef struct packed {
        logic       strobe_select;      // 1 = strobe-on-select
        logic       ext_wait_enable;
        logic [3:0] w_setup;
        logic [5:0] w_strobe;
        logic [2:0] w_hold;
        logic [3:0] r_setup;
        logic [5:0] r_strobe;
        logic [2:0] r_hold;
        logic [1:0] turnaround_cycles;
        logic [1:0] data_bus_width;
    } amtc_space_cfg_s;

    typedef struct packed {
        logic [3:0]      wait_polarity;      // Bit n for wait input n
        logic [3:0]      rsvd_hi;
        logic [3:0][1:0] wait_input_map;     // Entry n maps space n; entry 2 is the space 2 field
        logic [7:0]      rsvd_lo;
        logic [7:0]      max_ext_wait_count;
    } amtc_wait_cfg_s;

    typedef enum logic [1:0] {
        AMTC_IDLE,
        AMTC_SETUP,
        AMTC_STROBE,
        AMTC_HOLD
    } amtc_state_e;

endpackage

/* hw/amtc_core.sv */
// Timing and mode engine for four asynchronous memory chip-select spaces.
// Assumes an APB master on clk, a same-clock access requester, and
// ext_wait_input pins that are asynchronous to clk.
//
// Notes on behaviour
// R1: Space 2 map field picks one of four wait inputs, default input 2.
// R2: Extension lasts at most (max count + 1) x 16 cycles, then hold starts.
// R3: Four independent space configuration registers, one per chip select.
// R4: Configuration written before a transfer applies to every later transfer.
// R5: Bit 31 picks normal or strobe-on-select mode per space.
// R6: Bit 30 enables wait-input extension; cleared means no extension.
// R7: Write setup, strobe and hold each last field plus one cycles.
// R8: Read setup, strobe and hold each last field plus one cycles.
// R9: At least turnaround plus one idle cycles between two accesses.
// R10: No turnaround for same direction to the same space.
// R11: Width field: 0 gives 8-bit, 1 gives 16-bit, others reserved.
// R12: Software keeps extension disabled for NAND spaces.
// R13: Software keeps both strobe fields nonzero when extension is enabled.
// R14: Software keeps extension disabled where no wait input exists.
// R15: Per-input polarity: 0 waits while low, 1 waits while high.
// R16: Timeout flag set when wait input stays active past the maximum.
// R17: Access runs setup, strobe, hold; active wait prolongs strobe.
`timescale 1ns/1ps
`default_nettype none

module amtc_core
    import amtc_pkg::*;
#(
    parameter int NUM_SPACES = 4,
    parameter int NUM_WAIT   = 4
)(
    input  wire logic                  clk,            // Controller clock, 125 MHz
    input  wire logic                  rst,            // Async reset, active high
    input  wire logic                  ce,             // Clock enable, freezes state when low
    // APB slave
    input  wire logic                  psel,           // Slave select
    input  wire logic                  penable,        // Access phase
    input  wire logic                  pwrite,         // Write direction
    input  wire logic [7:0]            paddr,          // Byte address
    input  wire logic [31:0]           pwdata,         // Write data
    output logic                       pready,         // Transfer complete
    output logic [31:0]                prdata,         // Read data
    output logic                       pslverr,        // Unmapped address
    // Access request, same clock
    input  wire logic                  req_valid,      // Access requested
    input  wire logic                  req_write,      // 1 = write access
    input  wire logic [1:0]            req_space,      // Chip-select space
    output logic                       req_ready,      // Request taken this cycle
    output logic                       acc_done,       // Pulse at end of hold
    // Memory pins
    input  wire logic [NUM_WAIT-1:0]   ext_wait_input, // Wait pins, asynchronous
    output logic [NUM_SPACES-1:0]      mem_cs_n,       // Chip selects, active low
    output logic                       mem_oe_n,       // Read strobe, active low
    output logic                       mem_we_n,       // Write strobe, active low
    output logic                       mem_wide,       // 16-bit data bus in use
    output logic                       irq             // Level interrupt
);
    // Register state
    amtc_wait_cfg_s                     wait_cfg;
    amtc_space_cfg_s [NUM_SPACES-1:0]   space_cfg;
    logic [31:0]                        int_status;
    logic [31:0]                        int_mask;
    logic [31:0]                        rd_data;
    logic                               rd_err;
    amtc_wait_cfg_s                     next_wait_cfg;
    amtc_space_cfg_s [NUM_SPACES-1:0]   next_space_cfg;
    logic [31:0]                        next_int_status;
    logic [31:0]                        next_int_mask;
    logic [31:0]                        next_rd_data;
    logic                               next_rd_err;
    // Wait input synchronisers
    logic [NUM_WAIT-1:0]                wait_meta;
    logic [NUM_WAIT-1:0]                wait_sync;
    logic [NUM_WAIT-1:0]                wait_prev;
    logic [NUM_WAIT-1:0]                wait_rise;
    // Access engine state
    amtc_state_e                        state;
    amtc_space_cfg_s                    acc_cfg;
    logic [1:0]                         acc_space;
    logic                               acc_write;
    logic [5:0]                         phase_cnt;
    logic [12:0]                        ext_cnt;
    logic [2:0]                         gap_cnt;
    logic                               have_last;
    logic                               timeout_evt;
    logic                               done;
    logic [NUM_SPACES-1:0]              cs_n;
    logic                               oe_n;
    logic                               we_n;
    logic                               wide;
    amtc_state_e                        next_state;
    amtc_space_cfg_s                    next_acc_cfg;
    logic [1:0]                         next_acc_space;
    logic                               next_acc_write;
    logic [5:0]                         next_phase_cnt;
    logic [12:0]                        next_ext_cnt;
    logic [2:0]                         next_gap_cnt;
    logic                               next_have_last;
    logic                               next_timeout_evt;
    logic                               next_done;
    logic [NUM_SPACES-1:0]              next_cs_n;
    logic                               next_oe_n;
    logic                               next_we_n;
    logic                               next_wide;
    // Combinational helpers
    logic                               wr_en;
    logic                               setup_phase;
    logic                               gap_ok;
    logic [1:0]                         wait_sel;
    logic                               wait_active;
    logic [12:0]                        ext_limit;
    logic [7:0]                         space_off;
    logic [NUM_SPACES-1:0]              space_hit;
    // Answer in the first access-phase cycle; stalls only while ce is low
    assign pready      = psel & penable & ce;
    assign prdata      = rd_data;
    assign pslverr     = rd_err & pready;
    assign wr_en       = psel & penable & pwrite & ce;
    assign setup_phase = psel & ~penable;
    assign irq         = |(int_status & int_mask);
    assign acc_done    = done;
    assign mem_cs_n    = cs_n;
    assign mem_oe_n    = oe_n;
    assign mem_we_n    = we_n;
    assign mem_wide    = wide;

    // Address decode of the space registers
    assign space_off = paddr - AMTC_OFF_SPACE_BASE;
    generate
        for (genvar s = 0; s < NUM_SPACES; s++)
        begin : g_hit
            assign space_hit[s] = (paddr >= AMTC_OFF_SPACE_BASE) && (space_off == 8'(4 * s));
        end
    endgenerate
    // Edge detect reads only the second and third stages, never the first
    assign wait_rise = wait_sync & ~wait_prev;
    // Wait input chosen by the map entry of the active space
    assign wait_sel    = wait_cfg.wait_input_map[acc_space];                                   // see R1
    assign wait_active = (wait_sync[wait_sel] == wait_cfg.wait_polarity[wait_sel]);            // see R15
    assign ext_limit   = {({1'b0, wait_cfg.max_ext_wait_count} + 9'h001), 4'h0};               // see R2

    // Turnaround satisfied unless direction or space changes
    assign gap_ok = ~have_last
                  | ((req_write == acc_write) && (req_space == acc_space))                     // see R10
                  | (gap_cnt >= {1'b0, acc_cfg.turnaround_cycles});                            // see R9
    assign req_ready = ce & (state == AMTC_IDLE) & gap_ok;

    // Register next values: APB writes, sticky events and read capture
    always_comb
    begin
        next_wait_cfg   = wait_cfg;
        next_space_cfg  = space_cfg;
        next_int_status = int_status;
        next_int_mask   = int_mask;
        next_rd_data    = rd_data;
        next_rd_err     = rd_err;
        if (wr_en)
        begin
            if (paddr == AMTC_OFF_WAIT_CFG)
                next_wait_cfg = pwdata & AMTC_WAIT_CFG_WMASK;
            for (int s = 0; s < NUM_SPACES; s++)
            begin
                if (space_hit[s])
                    next_space_cfg[s] = pwdata;                                                // see R3
            end
            if (paddr == AMTC_OFF_INT_STATUS)
            begin
                // Write one clears status and the matching mask bit
                next_int_status = int_status & ~(pwdata & AMTC_INT_BITS);
                next_int_mask   = int_mask & ~(pwdata & AMTC_INT_BITS);
            end
            if (paddr == AMTC_OFF_INT_MASK)
                next_int_mask = pwdata & AMTC_INT_BITS;
        end
        // Set after clear so an event in the clearing cycle survives
        next_int_status[AMTC_INT_RISE_LSB +: NUM_WAIT] =
            next_int_status[AMTC_INT_RISE_LSB +: NUM_WAIT] | wait_rise;
        if (timeout_evt)
            next_int_status[AMTC_INT_TIMEOUT_BIT] = 1'b1;                                      // see R16
        // Read data is captured in the setup cycle
        if (setup_phase)
        begin
            next_rd_err  = 1'b0;
            next_rd_data = 32'h0000_0000;
            if (paddr == AMTC_OFF_WAIT_CFG)
                next_rd_data = wait_cfg;
            else if (paddr == AMTC_OFF_INT_STATUS)
                next_rd_data = int_status;
            else if (paddr == AMTC_OFF_INT_MASK)
                next_rd_data = int_mask;
            else if (paddr == AMTC_OFF_ACC_STATUS)
                next_rd_data = {28'h000_0000, acc_space, acc_write, state != AMTC_IDLE};
            else if (|space_hit)
                next_rd_data = space_cfg[space_off[3:2]];  // Hit means aligned and in range
            else
                next_rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cfg   <= AMTC_RST_WAIT_CFG;
            space_cfg  <= {NUM_SPACES{AMTC_RST_SPACE_CFG}};
            int_status <= AMTC_RST_INT;
            int_mask   <= AMTC_RST_INT;
            rd_data    <= 32'h0000_0000;
            rd_err     <= 1'b0;
        end
        else if (ce)
        begin
            wait_cfg   <= next_wait_cfg;
            space_cfg  <= next_space_cfg;
            int_status <= next_int_status;
            int_mask   <= next_int_mask;
            rd_data    <= next_rd_data;
            rd_err     <= next_rd_err;
        end
    end

    // Two-flop synchroniser plus one stage for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_meta <= '0;
            wait_sync <= '0;
            wait_prev <= '0;
        end
        else if (ce)
        begin
            wait_meta <= ext_wait_input;
            wait_sync <= wait_meta;
            wait_prev <= wait_sync;
        end
    end
    // Access sequencer: idle, setup, strobe with optional extension, hold
    always_comb
    begin
        next_state       = state;
        next_acc_cfg     = acc_cfg;
        next_acc_space   = acc_space;
        next_acc_write   = acc_write;
        next_phase_cnt   = phase_cnt;
        next_ext_cnt     = ext_cnt;
        next_gap_cnt     = gap_cnt;
        next_have_last   = have_last;
        next_timeout_evt = 1'b0;
        next_done        = 1'b0;
        case (state)
            AMTC_IDLE:
            begin
                if (gap_cnt != 3'h7)
                    next_gap_cnt = gap_cnt + 3'h1;
                if (req_valid && req_ready)
                begin
                    // Snapshot so the latest written settings govern this access
                    next_acc_cfg   = space_cfg[req_space];                                     // see R4
                    next_acc_space = req_space;
                    next_acc_write = req_write;
                    next_phase_cnt = req_write ? {2'h0, space_cfg[req_space].w_setup}          // see R7
                                               : {2'h0, space_cfg[req_space].r_setup};         // see R8
                    next_state     = AMTC_SETUP;
                end
            end
            AMTC_SETUP:
            begin
                if (phase_cnt == 6'h00)
                begin
                    next_phase_cnt = acc_write ? acc_cfg.w_strobe : acc_cfg.r_strobe;          // see R7 R8
                    next_ext_cnt   = 13'h0000;
                    next_state     = AMTC_STROBE;
                end
                else
                    next_phase_cnt = phase_cnt - 6'h01;
            end
            AMTC_STROBE:
            begin
                if (phase_cnt != 6'h00)
                    next_phase_cnt = phase_cnt - 6'h01;
                else if (acc_cfg.ext_wait_enable && wait_active && (ext_cnt < ext_limit))      // see R6 R17
                    next_ext_cnt = ext_cnt + 13'h0001;                                         // see R2
                else
                begin
                    // Still active at the limit: give up and flag it
                    next_timeout_evt = acc_cfg.ext_wait_enable & wait_active;                  // see R16
                    next_phase_cnt   = acc_write ? {3'h0, acc_cfg.w_hold} : {3'h0, acc_cfg.r_hold};
                    next_state       = AMTC_HOLD;                                              // see R17
                end
            end
            AMTC_HOLD:
            begin
                if (phase_cnt == 6'h00)
                begin
                    next_done      = 1'b1;
                    next_gap_cnt   = 3'h0;
                    next_have_last = 1'b1;
                    next_state     = AMTC_IDLE;
                end
                else
                    next_phase_cnt = phase_cnt - 6'h01;
            end
            default:
                next_state = AMTC_IDLE;
        endcase
    end
    // Pin levels follow the next state so they stay registered
    always_comb
    begin
        next_cs_n = {NUM_SPACES{1'b1}};
        next_oe_n = 1'b1;
        next_we_n = 1'b1;
        next_wide = (next_acc_cfg.data_bus_width == AMTC_WIDTH_16);                            // see R11
        if (next_state != AMTC_IDLE)
        begin
            // Strobe-on-select asserts the select only while strobing
            if (!next_acc_cfg.strobe_select || next_state == AMTC_STROBE)                      // see R5
                next_cs_n[next_acc_space] = 1'b0;
            if (next_state == AMTC_STROBE)
            begin
                next_we_n = ~next_acc_write;
                next_oe_n = next_acc_write;
            end
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state       <= AMTC_IDLE;
            acc_cfg     <= AMTC_RST_SPACE_CFG;
            acc_space   <= 2'h0;
            acc_write   <= 1'b0;
            phase_cnt   <= 6'h00;
            ext_cnt     <= 13'h0000;
            gap_cnt     <= 3'h0;
            have_last   <= 1'b0;
            timeout_evt <= 1'b0;
            done        <= 1'b0;
            cs_n        <= {NUM_SPACES{1'b1}};
            oe_n        <= 1'b1;
            we_n        <= 1'b1;
            wide        <= 1'b0;
        end
        else if (ce)
        begin
            state       <= next_state;
            acc_cfg     <= next_acc_cfg;
            acc_space   <= next_acc_space;
            acc_write   <= next_acc_write;
            phase_cnt   <= next_phase_cnt;
            ext_cnt     <= next_ext_cnt;
            gap_cnt     <= next_gap_cnt;
            have_last   <= next_have_last;
            timeout_evt <= next_timeout_evt;
            done        <= next_done;
            cs_n        <= next_cs_n;
            oe_n        <= next_oe_n;
            we_n        <= next_we_n;
            wide        <= next_wide;
        end
    end

endmodule

`default_nettype wire

/* tb/amtc_core_properties.sv */
// Checker on the core's access pins and request handshake.
// Sees only core ports; bound from the testbench top, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module amtc_core_properties
    import amtc_pkg::*;
#(
    parameter int NUM_SPACES = 4,
    parameter int NUM_WAIT   = 4
)(
    input wire logic                  clk,       // Controller clock
    input wire logic                  rst,       // Async reset
    input wire logic                  req_valid, // Request offered
    input wire logic                  req_ready, // Request taken
    input wire logic                  acc_done,  // End of access
    input wire logic [NUM_SPACES-1:0] mem_cs_n,  // Chip selects
    input wire logic                  mem_oe_n,  // Read strobe
    input wire logic                  mem_we_n   // Write strobe
);
    localparam int MAX_STB = 64 + 256 * AMTC_EXT_WAIT_UNIT;
    logic [12:0] stb_cnt;
    logic [12:0] next_stb_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Strobe run length; a counter, as the bound is far past a repetition
    always_comb
        next_stb_cnt = (!mem_oe_n || !mem_we_n) ? stb_cnt + 13'h1 : 13'h0;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            stb_cnt <= 13'h0;
        else
            stb_cnt <= next_stb_cnt;

    property p_one_cs; $onehot0(~mem_cs_n); endproperty
    a_one_cs: assert property (p_one_cs) else $error("two selects low");
    property p_no_both; !(!mem_oe_n && !mem_we_n); endproperty
    a_no_both: assert property (p_no_both) else $error("both strobes low");
    property p_strobe_cs; (!mem_oe_n || !mem_we_n) |-> (mem_cs_n != '1); endproperty
    a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
    property p_setup_first; (req_valid && req_ready) |=> (mem_oe_n && mem_we_n); endproperty
    a_setup_first: assert property (p_setup_first) else $error("no setup cycle");
    property p_hold_last; acc_done |-> (mem_cs_n == '1) && $past(mem_oe_n) && $past(mem_we_n); endproperty
    a_hold_last: assert property (p_hold_last) else $error("no hold cycle");
    property p_done_pulse; acc_done |=> !acc_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_busy_refuse; (mem_cs_n != '1) |-> !req_ready; endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("taken while busy");
    property p_accept_busy; (req_valid && req_ready) |=> !req_ready [*3]; endproperty
    a_accept_busy: assert property (p_accept_busy) else $error("access too short");
    property p_ext_bound; stb_cnt <= MAX_STB; endproperty
    a_ext_bound: assert property (p_ext_bound) else $error("extension too long");
endmodule

`default_nettype wire

/* tb/amtc_wait_model.sv */
// Memory-side model: drives the wait pins busy on command.
// Assumes the bench hands it the polarity it programmed.
`timescale 1ns/1ps
`default_nettype none

module amtc_wait_model
    import amtc_pkg::*;
(
    input  wire logic [3:0] cs_n,     // Chip selects
    input  wire logic [3:0] hold,     // Pins to hold busy
    input  wire logic [3:0] pol,      // Busy level per pin
    output logic      [3:0] wait_pin  // Wait lines to the core
);
    // Busy only while selected; a released line rests at its idle level
    always_comb
        wait_pin = pol ~^ (hold & {4{cs_n != 4'hF}});
endmodule

`default_nettype wire

/* tb/async_mem_timing_config_tb_top.sv */
// Testbench top for the asynchronous memory timing block.
// Assumes the wait model on the ext_wait_input pins.
`timescale 1ns/1ps
`default_nettype none

module async_mem_timing_config_tb_top;
    import amtc_pkg::*;
    logic            clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, r;
    logic            req_valid, req_write, req_ready, acc_done, oe_n, we_n, wide, irq, e;
    logic [1:0]      req_space;
    logic [3:0]      wait_pin, cs_n, hold, pol;
    amtc_space_cfg_s cf [4];
    int              num_errors, n_compared, cyc, t_acc, t_done, gap, stb, csl;

    amtc_core i_amtc_core (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write), .req_space(req_space),
        .req_ready(req_ready), .acc_done(acc_done), .ext_wait_input(wait_pin), .mem_cs_n(cs_n),
        .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_wide(wide), .irq(irq));
    amtc_wait_model i_amtc_wait_model (.cs_n(cs_n), .hold(hold), .pol(pol), .wait_pin(wait_pin));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Record of the latest access, plus the hang limit
    always @(posedge clk)
    begin
        cyc++;
        if (acc_done) t_done = cyc;
        if (req_valid && req_ready)
        begin
            gap = cyc - t_done;
            t_acc = cyc;
            stb = 0;
            csl = 0;
        end
        if (!oe_n || !we_n) stb++;
        if (cs_n != 4'hF) csl++;
        if (cyc > 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk(e, 0, "write error");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(r, exp, "read data");
        chk(e, err, "read error");
    endtask

    // Two requests back to back; the second is the one measured
    task automatic pair(input logic w0, input logic [1:0] s0, input logic w1, input logic [1:0] s1);
        req_valid <= 1'b1;
        req_write <= w0;
        req_space <= s0;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_write <= w1;
        req_space <= s1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (acc_done !== 1'b1);
        @(posedge clk);
    endtask

    task automatic acc_chk(input logic w, input int s, input int ext);
        int su, st, h;
        su = w ? cf[s].w_setup : cf[s].r_setup;
        st = w ? cf[s].w_strobe : cf[s].r_strobe;
        h = w ? cf[s].w_hold : cf[s].r_hold;
        chk(stb, st + 1 + ext, "strobe width");
        chk(t_done - t_acc, su + st + h + 4 + ext, "access length");
        chk(csl, cf[s].strobe_select ? st + 1 + ext : su + st + h + 3 + ext, "select width");
    endtask

    initial
    begin
        {rst, ce, pol} = {1'b1, 1'b1, 4'hF};
        {psel, penable, pwrite, paddr, pwdata, req_valid, req_write, req_space, hold} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(AMTC_OFF_WAIT_CFG, AMTC_RST_WAIT_CFG, 1'b0);
        rd(8'h30, 32'h0, 1'b1);
        // Distinct settings per space, all width codes
        for (int s = 0; s < 4; s++)
        begin
            rd(AMTC_OFF_SPACE_BASE + 8'(4 * s), AMTC_RST_SPACE_CFG, 1'b0);
            cf[s] = '{s[0], 1'b0, 4'(s + 1), 6'(s + 2), 3'(s), 4'(s), 6'(s + 3), 3'(s + 1), 2'(s), 2'(s)};
            wr(AMTC_OFF_SPACE_BASE + 8'(4 * s), cf[s]);
        end
        for (int s = 0; s < 4; s++)
        begin
            rd(AMTC_OFF_SPACE_BASE + 8'(4 * s), cf[s], 1'b0);
            for (int w = 0; w < 2; w++)
            begin
                pair(w[0], 2'(s), w[0], 2'(s));
                chk(gap, 0, "same direction gap");
                acc_chk(w[0], s, 0);
                chk(wide, s == 1, "bus width");
            end
            pair(1'b0, 2'(s), 1'b1, 2'(s));
            chk(gap, s, "turnaround gap");
        end
        rd(AMTC_OFF_ACC_STATUS, 32'h0000_000E, 1'b0);
        // Extension on space 0, each wait input mapped in turn
        cf[0] = '{1'b0, 1'b1, 4'h3, 6'h4, 3'h1, 4'h3, 6'h4, 3'h1, 2'h0, 2'h0};
        wr(AMTC_OFF_SPACE_BASE, cf[0]);
        pol <= 4'h5;
        for (int k = 0; k < 4; k++)
        begin
            wr(AMTC_OFF_WAIT_CFG, 32'h5000_0000 | (k << 16) | (k % 2));
            wr(AMTC_OFF_INT_MASK, {31'h0, k != 3});
            hold <= 4'(1 << k);
            pair(1'b0, 2'h0, 1'b0, 2'h0);
            acc_chk(1'b0, 0, (k % 2 + 1) * 16);
            rd(AMTC_OFF_INT_STATUS, {26'h0, 1'b1, k != 0, 4'hD}, 1'b0);
            chk(r[0], 1, "timeout flag");
            chk(irq, k != 3, "interrupt level");
            wr(AMTC_OFF_INT_STATUS, 32'h1);
            chk(irq, 0, "interrupt cleared");
            hold <= ~4'(1 << k);
            pair(1'b1, 2'h0, 1'b1, 2'h0);
            acc_chk(1'b1, 0, 0);
        end
        cf[0].ext_wait_enable = 1'b0;
        wr(AMTC_OFF_SPACE_BASE, cf[0]);
        hold <= 4'hF;
        pair(1'b0, 2'h0, 1'b0, 2'h0);
        acc_chk(1'b0, 0, 0);
        repeat (4) @(posedge clk);
        wr(AMTC_OFF_INT_STATUS, AMTC_INT_BITS);
        rd(AMTC_OFF_INT_STATUS, 32'h0, 1'b0);
        summarize();
    end
endmodule

bind amtc_core amtc_core_properties #(.NUM_SPACES(NUM_SPACES), .NUM_WAIT(NUM_WAIT)) i_amtc_core_properties (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .acc_done(acc_done),
    .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n));

`default_nettype wire
